/* File: hdl/asscd_pkg.sv */
package asscd_pkg;

  // Command opcodes.
  localparam logic [7:0] CMD_SLEEP_A    = 8'hE6;
  localparam logic [7:0] CMD_SLEEP_B    = 8'h99;
  localparam logic [7:0] CMD_SMART      = 8'hB0;

  // SMART subcommand codes carried in the features register.
  localparam logic [7:0] SUB_READ_VAL   = 8'hD0;
  localparam logic [7:0] SUB_READ_THR   = 8'hD1;
  localparam logic [7:0] SUB_AUTOSAVE   = 8'hD2;
  localparam logic [7:0] SUB_SAVE       = 8'hD3;
  localparam logic [7:0] SUB_OFFLINE    = 8'hD4;
  localparam logic [7:0] SUB_LOG_RD     = 8'hD5;
  localparam logic [7:0] SUB_LOG_WR     = 8'hD6;
  localparam logic [7:0] SUB_ENABLE     = 8'hD8;
  localparam logic [7:0] SUB_DISABLE    = 8'hD9;
  localparam logic [7:0] SUB_RET_STATUS = 8'hDA;
  localparam logic [7:0] SUB_AUTO_OFFL  = 8'hDB;

  // Autosave sector count values and the SMART key.
  localparam logic [7:0] AUTOSAVE_OFF   = 8'h00;
  localparam logic [7:0] AUTOSAVE_ON    = 8'hF1;
  localparam logic [7:0] KEY_CYL_LO     = 8'h4F;
  localparam logic [7:0] KEY_CYL_HI     = 8'hC2;

  // Device/head register field positions.
  localparam int DEV_SEL_BIT  = 4;

  // Status and error register bit positions.
  localparam int ST_BSY = 7;
  localparam int ST_RDY = 6;
  localparam int ST_DSC = 4;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;

  // Sector transfer length in bytes.
  localparam int SECTOR_BYTES = 512;

  // Register port map.
  localparam logic [3:0] ADR_CTRL     = 4'h0;
  localparam logic [3:0] ADR_STATE    = 4'h1;
  localparam logic [3:0] ADR_IRQ_STAT = 4'h2;
  localparam logic [3:0] ADR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADR_DEV_ID   = 4'h4;

  // Control register fields.
  localparam int CTRL_DEV_ADDR = 0;

  // Interrupt event bits.
  localparam int IRQ_CMD_DONE = 0;
  localparam int IRQ_SLEEP    = 1;
  localparam int IRQ_ABORT    = 2;
  localparam int IRQ_WIDTH    = 3;

  // Reset values.
  localparam logic [7:0] STATUS_RST = 8'h50;
  localparam logic [7:0] ERROR_RST  = 8'h00;

endpackage

/* File: hdl/asscd_nv_bit.sv */
`timescale 1ns/1ps
// Nonvolatile flag model: reset does not touch the stored value except on first power.
module asscd_nv_bit (
  // Clock
  input  wire logic sys_clk,
  // Power-on
  input  wire logic por,
  // Update
  input  wire logic wr_en,
  input  wire logic wr_val,
  // Stored value
  output logic      q
);

  // Only power-on clears it; a host reset keeps the stored setting.
  always_ff @(posedge sys_clk or posedge por) begin
    if (por) begin
      q <= 1'b0;
    end else if (wr_en) begin
      q <= wr_val;
    end
  end

endmodule

/* File: hdl/asscd_decoder.sv */
`timescale 1ns/1ps
module asscd_decoder
  import asscd_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       por,
  input  wire logic       soft_reset,
  // Task file from host
  input  wire logic       cmd_wr,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] features,
  input  wire logic [7:0] sector_count,
  input  wire logic [7:0] cyl_low,
  input  wire logic [7:0] cyl_high,
  input  wire logic [7:0] dev_head,
  // Task file to host
  output logic [7:0]      status,
  output logic [7:0]      error,
  output logic            intrq,
  // Sector data stream to host
  output logic            data_valid,
  output logic [7:0]      data_byte,
  input  wire logic       data_ready,
  // Media and attribute store
  input  wire logic       spindle_stopped,
  output logic            spin_down_req,
  input  wire logic       spin_down_done,
  output logic            attr_save_req,
  output logic            thr_fetch_req,
  input  wire logic       store_done,
  input  wire logic [7:0] sector_rd_data,
  output logic [8:0]      sector_rd_addr,
  output logic            iface_active,
  output logic            smart_enabled,
  output logic            autosave_enabled,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  output logic            irq
);

  typedef enum logic [3:0] {
    S_IDLE     = 4'b0000,
    S_SPIN     = 4'b0001,
    S_SLEEP    = 4'b0010,
    S_SAVE     = 4'b0011,
    S_FETCH    = 4'b0100,
    S_XFER     = 4'b0101,
    S_AS_UPD   = 4'b0110,
    S_AS_DONE  = 4'b0111,
    S_EN_SAVE  = 4'b1000,
    S_DONE     = 4'b1001
  } asscd_state_e;

  function automatic logic is_listed(input logic [7:0] c);
    is_listed = (c >= SUB_READ_VAL && c <= SUB_LOG_WR) || (c >= SUB_ENABLE && c <= SUB_AUTO_OFFL);
  endfunction

  asscd_state_e   state_r;
  asscd_state_e   state_nxt;
  logic [8:0]     byte_cnt_r;
  logic           dev_addr_r;
  logic [IRQ_WIDTH-1:0] irq_stat_r;
  logic [IRQ_WIDTH-1:0] irq_mask_r;
  logic           smart_wr;
  logic           smart_val;
  logic           as_wr;
  logic           as_val;
  logic           ev_done;
  logic           ev_sleep;
  logic           ev_abort;
  logic           dev_match;
  logic           smart_bad;
  logic           take_smart;

  assign dev_match  = dev_head[DEV_SEL_BIT] == dev_addr_r;
  // Features must already hold the subcommand when the opcode lands.
  assign smart_bad  = !is_listed(features)
                      || (cyl_low != KEY_CYL_LO) || (cyl_high != KEY_CYL_HI)
                      || (!smart_enabled && features != SUB_ENABLE);
  assign take_smart = state_r == S_IDLE && cmd_wr && dev_match && cmd_code == CMD_SMART;

  // Enable/disable flags live in nonvolatile cells that survive resets.
  asscd_nv_bit u_smart_nv (
    .sys_clk (sys_clk),
    .por     (por),
    .wr_en   (smart_wr),
    .wr_val  (smart_val),
    .q       (smart_enabled)
  );

  asscd_nv_bit u_autosave_nv (
    .sys_clk (sys_clk),
    .por     (por),
    .wr_en   (as_wr),
    .wr_val  (as_val),
    .q       (autosave_enabled)
  );

  always_comb begin
    state_nxt = state_r;
    smart_wr  = 1'b0;
    smart_val = 1'b0;
    as_wr     = 1'b0;
    as_val    = 1'b0;
    ev_done   = 1'b0;
    ev_sleep  = 1'b0;
    ev_abort  = 1'b0;
    case (state_r)
      S_IDLE: begin
        if (cmd_wr && dev_match && (cmd_code == CMD_SLEEP_A || cmd_code == CMD_SLEEP_B)) begin
          state_nxt = spindle_stopped ? S_SLEEP : S_SPIN;
          ev_sleep  = spindle_stopped;
        end else if (take_smart) begin
          if (smart_bad) begin
            ev_abort  = 1'b1;
            state_nxt = S_IDLE;
          end else begin
            case (features)
              SUB_READ_VAL: state_nxt = S_SAVE;
              SUB_READ_THR: state_nxt = S_FETCH;
              SUB_AUTOSAVE: begin
                if (sector_count == AUTOSAVE_OFF || sector_count == AUTOSAVE_ON) begin
                  state_nxt = S_AS_UPD;
                end else begin
                  ev_abort = 1'b1;
                end
              end
              SUB_ENABLE: begin
                smart_wr  = 1'b1;
                smart_val = 1'b1;
                state_nxt = S_EN_SAVE;
              end
              SUB_DISABLE: begin
                smart_wr  = 1'b1;
                as_wr     = 1'b1;
                state_nxt = S_EN_SAVE;
              end
              default: ev_done = 1'b1;
            endcase
          end
        end
      end
      S_SPIN: begin
        if (spin_down_done) begin
          state_nxt = S_SLEEP;
          ev_sleep  = 1'b1;
        end
      end
      S_SLEEP: state_nxt = S_SLEEP;
      S_SAVE: begin
        if (store_done) begin
          state_nxt = S_XFER;
        end
      end
      S_FETCH: begin
        if (store_done) begin
          state_nxt = S_XFER;
        end
      end
      S_XFER: begin
        if (data_ready && byte_cnt_r == 9'(SECTOR_BYTES - 1)) begin
          state_nxt = S_IDLE;
          ev_done   = 1'b1;
        end
      end
      S_AS_UPD: begin
        as_wr     = 1'b1;
        as_val    = sector_count == AUTOSAVE_ON;
        state_nxt = S_AS_DONE;
      end
      S_AS_DONE: begin
        state_nxt = S_IDLE;
        ev_done   = 1'b1;
      end
      S_EN_SAVE: begin
        if (store_done) begin
          state_nxt = S_DONE;
        end
      end
      S_DONE: begin
        state_nxt = S_IDLE;
        ev_done   = 1'b1;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  // Soft reset is the second exit from sleep beside the hardware reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
    end else if (soft_reset) begin
      state_r <= S_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      byte_cnt_r <= 9'h000;
    end else if (state_r != S_XFER || soft_reset) begin
      byte_cnt_r <= 9'h000;
    end else if (data_ready) begin
      byte_cnt_r <= byte_cnt_r + 9'h001;
    end
  end

  assign data_valid     = state_r == S_XFER;
  assign data_byte      = sector_rd_data;
  assign sector_rd_addr = byte_cnt_r;
  assign spin_down_req  = state_r == S_SPIN;
  assign iface_active   = state_r != S_SLEEP;
  // Power-up and power-down saves are left to firmware, whatever the autosave flag says.
  assign attr_save_req  = state_r == S_SAVE || state_r == S_EN_SAVE;
  assign thr_fetch_req  = state_r == S_FETCH;

  // Task-file status: BSY follows any non-idle state except sleep and S_AS_DONE.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= STATUS_RST;
      error  <= ERROR_RST;
    end else if (soft_reset) begin
      status <= STATUS_RST;
      error  <= ERROR_RST;
    end else begin
      // Autosave drops BSY one cycle ahead of INTRQ, so the host sees the two in order.
      status[ST_BSY] <= state_nxt != S_IDLE && state_nxt != S_SLEEP && state_nxt != S_AS_DONE;
      status[ST_DRQ] <= state_nxt == S_XFER;
      if (take_smart || (state_r == S_IDLE && cmd_wr)) begin
        status[ST_ERR] <= ev_abort;
        error[ER_ABT]  <= ev_abort;
      end
    end
  end

  // INTRQ rises on the same edge that drops BSY, except after autosave, where BSY drops one cycle earlier, and on entering sleep, where it stays low.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intrq <= 1'b0;
    end else if (soft_reset) begin
      intrq <= 1'b0;
    end else if (ev_done || ev_abort) begin
      // A command that ends at once raises INTRQ in the cycle of its own write, so the event wins.
      intrq <= 1'b1;
    end else if (cmd_wr) begin
      intrq <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dev_addr_r <= 1'b0;
      irq_mask_r <= '0;
    end else if (reg_wr && reg_addr == ADR_CTRL) begin
      dev_addr_r <= reg_wdata[CTRL_DEV_ADDR];
    end else if (reg_wr && reg_addr == ADR_IRQ_MASK) begin
      irq_mask_r <= reg_wdata[IRQ_WIDTH-1:0];
    end
  end

  // A new event in the clearing cycle wins over the write-one clear.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((reg_wr && reg_addr == ADR_IRQ_STAT) ? reg_wdata[IRQ_WIDTH-1:0] : '0))
                    | {ev_abort, ev_sleep, ev_done};
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADR_CTRL:     reg_rdata <= {7'h00, dev_addr_r};
        ADR_STATE:    reg_rdata <= {2'h0, autosave_enabled, smart_enabled, state_r};
        ADR_IRQ_STAT: reg_rdata <= {5'h00, irq_stat_r};
        ADR_IRQ_MASK: reg_rdata <= {5'h00, irq_mask_r};
        default:      reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule

/* File: tb/asscd_props.sv */
`timescale 1ns/1ps
module asscd_props
  import asscd_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       soft_reset,
  // Task file
  input wire logic       cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] features,
  input wire logic [7:0] sector_count,
  input wire logic [7:0] cyl_low,
  input wire logic [7:0] cyl_high,
  input wire logic [7:0] dev_head,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic       intrq,
  // Media and flags
  input wire logic       spindle_stopped,
  input wire logic       spin_down_req,
  input wire logic       iface_active,
  input wire logic       smart_enabled,
  input wire logic       autosave_enabled
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic go, slp, key, smt, ok, lst, cnt;
  assign go  = cmd_wr && !status[ST_BSY] && !status[ST_DRQ] && iface_active && !dev_head[DEV_SEL_BIT];
  assign slp = go && (cmd_code == CMD_SLEEP_A || cmd_code == CMD_SLEEP_B);
  assign key = cyl_low == KEY_CYL_LO && cyl_high == KEY_CYL_HI;
  assign smt = go && cmd_code == CMD_SMART;
  assign ok  = smt && key && smart_enabled;
  assign lst = features inside {[8'hD0:8'hD6], [8'hD8:8'hDB]};
  assign cnt = sector_count == AUTOSAVE_OFF || sector_count == AUTOSAVE_ON;
  sequence abort_s;
    intrq && error[ER_ABT] && status[ST_ERR];
  endsequence
  // The flag is judged two edges after the request, when BSY has just dropped.
  sequence as_s;
    status[ST_BSY] ##1 (!status[ST_BSY] && autosave_enabled == $past(sector_count == AUTOSAVE_ON, 2)) ##1 intrq;
  endsequence
  sleep_enter_a: assert property (slp && !spindle_stopped |=> spin_down_req)
    else $error("sleep did not start spin-down");
  spin_skip_a: assert property (spin_down_req |-> !spindle_stopped)
    else $error("spin-down with media stopped");
  sleep_hold_a: assert property (!iface_active && !soft_reset |=> !iface_active)
    else $error("sleep left without reset");
  autosave_seq_a: assert property (ok && features == SUB_AUTOSAVE && cnt |=> as_s)
    else $error("autosave handshake wrong");
  autosave_bad_a: assert property (ok && features == SUB_AUTOSAVE && !cnt |=> abort_s and $stable(autosave_enabled))
    else $error("bad autosave count not refused");
  disable_clr_a: assert property (ok && features == SUB_DISABLE |-> ##[1:40] !smart_enabled && !autosave_enabled)
    else $error("disable left a flag set");
  smart_off_a: assert property (smt && key && !smart_enabled && features != SUB_ENABLE |=> abort_s)
    else $error("command taken with SMART off");
  key_abort_a: assert property (smt && !key |=> abort_s)
    else $error("missing key not refused");
  unlisted_a: assert property (ok && !lst |=> abort_s)
    else $error("unlisted code not refused");
endmodule

bind asscd_decoder asscd_props i_asscd_props (.sys_clk, .rst, .soft_reset, .cmd_wr, .cmd_code, .features,
  .sector_count, .cyl_low, .cyl_high, .dev_head, .status, .error, .intrq, .spindle_stopped, .spin_down_req,
  .iface_active, .smart_enabled, .autosave_enabled);

/* File: tb/asscd_store_model.sv */
`timescale 1ns/1ps
// Spindle and attribute store; each request is answered once, DLY+1 cycles after it rises.
module asscd_store_model #(
  parameter int DLY = 4
) (
  // Clock
  input  wire logic       sys_clk,
  // Requests
  input  wire logic       spin_down_req,
  input  wire logic       attr_save_req,
  input  wire logic       thr_fetch_req,
  input  wire logic [8:0] sector_rd_addr,
  // Answers
  output logic            spin_down_done,
  output logic            store_done,
  output logic [7:0]      sector_rd_data
);
  int n = 0;
  assign sector_rd_data = sector_rd_addr[7:0] ^ 8'hA5;
  always_ff @(posedge sys_clk) begin
    n              <= (spin_down_req || attr_save_req || thr_fetch_req) ? n + 1 : 0;
    spin_down_done <= spin_down_req && n == DLY;
    store_done     <= (attr_save_req || thr_fetch_req) && n == DLY;
  end
endmodule

/* File: tb/test_asscd_decoder.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_ata_sleep_smart_command_decoder
  import asscd_pkg::*;
;
  logic       sys_clk = 1'b0, rst = 1'b1, por = 1'b1, soft_reset = 1'b0, cmd_wr = 1'b0;
  logic       data_ready = 1'b0, spindle_stopped = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] cmd_code = '0, features = '0, sector_count = '0, cyl_low = '0, cyl_high = '0;
  logic [7:0] dev_head = 8'hA0, reg_wdata = '0, status, error, data_byte, sector_rd_data, reg_rdata, d;
  logic [3:0] reg_addr = '0;
  logic [8:0] sector_rd_addr;
  logic       intrq, data_valid, spin_down_req, spin_down_done, attr_save_req, thr_fetch_req, store_done;
  logic       iface_active, smart_enabled, autosave_enabled, irq, saw_sv, saw_ft, saw_sp;
  int         n_mismatch = 0, total_checks = 0, nb = 0;

  asscd_decoder i_asscd_decoder (.sys_clk, .rst, .por, .soft_reset, .cmd_wr, .cmd_code, .features,
    .sector_count, .cyl_low, .cyl_high, .dev_head, .status, .error, .intrq, .data_valid, .data_byte,
    .data_ready, .spindle_stopped, .spin_down_req, .spin_down_done, .attr_save_req, .thr_fetch_req,
    .store_done, .sector_rd_data, .sector_rd_addr, .iface_active, .smart_enabled, .autosave_enabled,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  asscd_store_model i_asscd_store_model (.sys_clk, .spin_down_req, .attr_save_req, .thr_fetch_req,
    .sector_rd_addr, .spin_down_done, .store_done, .sector_rd_data);

  always #12.5 sys_clk = ~sys_clk;
  // The host takes a byte only every other cycle, so the stream stalls on alternate cycles throughout.
  always @(posedge sys_clk) data_ready <= ~data_ready;
  always @(posedge sys_clk) begin
    if (attr_save_req) saw_sv <= 1'b1;
    if (thr_fetch_req) saw_ft <= 1'b1;
    if (spin_down_req) saw_sp <= 1'b1;
    if (data_valid === 1'b1 && data_ready === 1'b1) begin
      `CHK({sector_rd_addr, data_byte}, {nb[8:0], nb[7:0] ^ 8'hA5})
      nb <= nb + 1;
    end
  end

  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  // Sleep commands are judged by the interface going idle, all others by the interrupt or by an already idle interface.
  task cmd(input logic [7:0] c, input logic [7:0] f, input logic [7:0] n, input logic k = 1'b1);
    int i;
    logic s;
    s = c == CMD_SLEEP_A || c == CMD_SLEEP_B;
    saw_sv = 1'b0;
    saw_ft = 1'b0;
    saw_sp = 1'b0;
    @(posedge sys_clk);
    features     <= f;
    sector_count <= n;
    cyl_low      <= k ? KEY_CYL_LO : 8'h00;
    cyl_high     <= KEY_CYL_HI;
    @(posedge sys_clk);
    cmd_code <= c;
    cmd_wr   <= 1'b1;
    @(posedge sys_clk);
    cmd_wr <= 1'b0;
    @(negedge sys_clk);
    for (i = 0; i < 3000 && (intrq !== 1'b1 || s) && iface_active !== 1'b0; i++) @(negedge sys_clk);
    `CHK(i < 3000, 1'b1)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task t_regs_irq;
    rd(4'hF);
    `CHK(d, 8'h00)
    rd(ADR_STATE);
    `CHK(d[5:4], 2'b00)
    wr(ADR_IRQ_MASK, 8'h00);
    cmd(CMD_SMART, SUB_READ_VAL, 8'h01);
    `CHK({error[ER_ABT], status[ST_ERR], irq}, 3'b110)
    rd(ADR_IRQ_STAT);
    `CHK(d[IRQ_ABORT], 1'b1)
    wr(ADR_IRQ_MASK, 8'h07);
    rd(ADR_IRQ_MASK);
    `CHK({d, irq}, 9'h00F)
    wr(ADR_IRQ_STAT, 8'h07);
    @(negedge sys_clk);
    `CHK(irq, 1'b0)
    $display("test regs_irq done");
  endtask
  task t_autosave;
    cmd(CMD_SMART, SUB_ENABLE, 8'h00);
    `CHK({smart_enabled, saw_sv, error[ER_ABT]}, 3'b110)
    cmd(CMD_SMART, SUB_AUTOSAVE, AUTOSAVE_ON);
    `CHK({autosave_enabled, error[ER_ABT]}, 2'b10)
    cmd(CMD_SMART, SUB_AUTOSAVE, 8'h05);
    `CHK({autosave_enabled, error[ER_ABT]}, 2'b11)
    cmd(CMD_SMART, SUB_AUTOSAVE, AUTOSAVE_OFF);
    `CHK(autosave_enabled, 1'b0)
    cmd(CMD_SMART, SUB_AUTOSAVE, AUTOSAVE_ON);
    cmd(CMD_SMART, SUB_DISABLE, 8'h00);
    `CHK({smart_enabled, autosave_enabled}, 2'b00)
    cmd(CMD_SMART, SUB_DISABLE, 8'h00);
    `CHK(error[ER_ABT], 1'b1)
    cmd(CMD_SMART, SUB_ENABLE, 8'h00);
    $display("test autosave done");
  endtask
  task t_codes;
    logic [7:0] codes [6] = '{SUB_SAVE, SUB_OFFLINE, SUB_LOG_RD, SUB_LOG_WR, SUB_RET_STATUS, SUB_AUTO_OFFL};
    foreach (codes[j]) begin
      cmd(CMD_SMART, codes[j], 8'h01);
      `CHK({intrq, error[ER_ABT]}, 2'b10)
    end
    cmd(CMD_SMART, SUB_SAVE, 8'h01, 1'b0);
    `CHK({error[ER_ABT], status[ST_ERR]}, 2'b11)
    cmd(CMD_SMART, 8'hD7, 8'h01);
    `CHK({error[ER_ABT], status[ST_ERR]}, 2'b11)
    $display("test codes done");
  endtask
  task t_read;
    nb = 0;
    cmd(CMD_SMART, SUB_READ_VAL, 8'h01);
    `CHK({nb, saw_sv, saw_ft}, {SECTOR_BYTES, 2'b10})
    nb = 0;
    cmd(CMD_SMART, SUB_READ_THR, 8'h01);
    `CHK({nb, saw_sv, saw_ft}, {SECTOR_BYTES, 2'b01})
    `CHK(status, STATUS_RST)
    $display("test read done");
  endtask
  task t_sleep;
    // A sleep opcode meant for the other device on the cable must be ignored.
    @(posedge sys_clk);
    dev_head <= 8'hB0;
    cmd_code <= CMD_SLEEP_A;
    cmd_wr   <= 1'b1;
    @(posedge sys_clk);
    dev_head <= 8'hA0;
    cmd_wr   <= 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK({iface_active, spin_down_req, status[ST_BSY]}, 3'b100)
    cmd(CMD_SLEEP_A, 8'h00, 8'h00);
    `CHK({saw_sp, iface_active}, 2'b10)
    cmd(CMD_SMART, SUB_DISABLE, 8'h00);
    repeat (20) @(negedge sys_clk);
    `CHK(smart_enabled, 1'b1)
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset      <= 1'b0;
    spindle_stopped <= 1'b1;
    @(negedge sys_clk);
    `CHK(iface_active, 1'b1)
    cmd(CMD_SLEEP_B, 8'h00, 8'h00);
    `CHK({saw_sp, iface_active}, 2'b00)
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    `CHK({iface_active, smart_enabled}, 2'b11)
    $display("test sleep done");
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_regs_irq();
    t_autosave();
    t_codes();
    t_read();
    t_sleep();
    final_report();
  end
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end
endmodule
